// *** rtl/rxeq_select_ctrl.sv ***
/*
 * Receive equalization select control for a two-lane redriver: strap capture,
 * configuration registers, fixed, fast adaptive and sweep adaptive selection.
 * Assumes the eye estimator and the insertion detector run on this clock and
 * that the four-level strap pins are already resolved into two-bit level codes.
 */
// Implementation choices: the placing of the registers and the strobed register port.
// How it works
// - Each of the four receivers has its own register setting; in strap mode each side shares one strap index.
// - Connector straps: index is four times high level plus low level.
// - Host straps decode the same way into index 0 to 15.
// - In serial mode four per-receiver fields replace the strap index.
// - Sweep mode steps from index 0 to the upper limit, then adopts the best.
// - Upper limit resets to 8, so nine candidates; software may change it.
// - Offset sign 0 adds the offset magnitude to the sweep result.
// - Offset sign 1 subtracts the offset magnitude from the sweep result.
// - The added result saturates at index 15.
// - Sweep mode works in both modes; in strap mode the disable strap gates it.
// - Fast mode applies the short setting for a short channel, else the long one.
// - Short means eye height at or above the writable limit field.
// - Fast mode is never selected in strap mode.
// - Programmed short and long settings are ignored while the use bit is clear.
// - Straps are sampled once just after reset release and then held.
// - Mode level F selects serial mode, level 1 strap mode; 0 and R reserved.
// - Host receivers are fixed only; adaptation is for connector receivers.
`timescale 1ns/1ps

module rxeq_select_ctrl
#(
   parameter logic [7:0] EYE_LIMIT_DEFAULT = rxeq_pkg::EYE_LIMIT_RST
)
(
   // Clock, reset and clock enable.
   input  wire logic                     clock,
   input  wire logic                     arst_n,
   input  wire logic                     clk_en,
   // Strap pins; the four-level ones as level codes 0, R, F, 1 = 0..3.
   input  wire logic [1:0]               mode_strap,
   input  wire logic [1:0]               conn_eq_strap_high,
   input  wire logic [1:0]               conn_eq_strap_low,
   input  wire logic [1:0]               host_eq_strap_high,
   input  wire logic [1:0]               host_eq_strap_low,
   input  wire logic                     adaptive_disable_strap_n,
   // Analog front end of the connector-facing receivers.
   input  wire logic [1:0]               insert_pulse,
   input  wire rxeq_pkg::rxeq_eye_t      eye_lane1,
   input  wire rxeq_pkg::rxeq_eye_t      eye_lane2,
   // Register port.
   input  wire logic [7:0]               reg_addr,
   input  wire logic [31:0]              reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output      logic [31:0]              reg_rdata,
   // Applied settings and status.
   output      rxeq_pkg::rxeq_settings_t eq_settings,
   output      logic                     serial_mode,
   output      logic [1:0]               adapt_busy
);

   // ***************************************************************
   // Strap synchronisers and one-time capture.
   // ***************************************************************
   logic [10:0] strap_meta_r;
   logic [10:0] strap_sync_r;
   logic [10:0] strap_held_r;
   logic [1:0]  take_cnt_r;
   logic        taken_r;

   // Two flops before anything reads the pins.
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         strap_meta_r <= 11'h000;
         strap_sync_r <= 11'h000;
      end
      else if (clk_en)
      begin
         strap_meta_r <= {adaptive_disable_strap_n, mode_strap, conn_eq_strap_high,
                          conn_eq_strap_low, host_eq_strap_high, host_eq_strap_low};
         strap_sync_r <= strap_meta_r;
      end
   end

   // The pull resistors are cut after sampling, so the pins are taken once only.
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         take_cnt_r   <= 2'h0;
         taken_r      <= 1'b0;
         strap_held_r <= 11'h000;
      end
      else if (clk_en && !taken_r)
      begin
         if (take_cnt_r == rxeq_pkg::STRAP_TAKE_CNT)
         begin
            strap_held_r <= strap_sync_r;
            taken_r      <= 1'b1;
         end
         else
            take_cnt_r <= take_cnt_r + 2'h1;
      end
   end

   logic       adapt_en_strap;
   logic [1:0] mode_lvl;
   logic [3:0] conn_strap_idx;
   logic [3:0] host_strap_idx;
   logic       serial_now;

   // Concatenating the two levels is four times high plus low.
   assign adapt_en_strap = strap_held_r[10];
   assign mode_lvl       = strap_held_r[9:8];
   assign conn_strap_idx = strap_held_r[7:4];
   assign host_strap_idx = strap_held_r[3:0];
   // Reserved mode levels fall back to strap mode.
   assign serial_now     = taken_r && (mode_lvl == rxeq_pkg::LVL_F);

   // ***************************************************************
   // Configuration registers.
   // ***************************************************************
   logic [3:0] conn_rx_lane1_eq_setting_r;
   logic [3:0] conn_rx_lane2_eq_setting_r;
   logic [3:0] host_rx_lane1_eq_setting_r;
   logic [3:0] host_rx_lane2_eq_setting_r;
   logic [7:0] long_channel_eq_setting_r;
   logic [1:0] mode_sel_r;
   logic       programmed_eq_use_r;
   logic       eq_offset_sign_r;
   logic [3:0] eq_offset_magnitude_r;
   logic [3:0] sweep_upper_limit_r;
   logic [7:0] eye_height_limits_r;

   // Software writes land in one cycle; the bus never waits.
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         conn_rx_lane1_eq_setting_r <= 4'h0;
         conn_rx_lane2_eq_setting_r <= 4'h0;
         host_rx_lane1_eq_setting_r <= 4'h0;
         host_rx_lane2_eq_setting_r <= 4'h0;
         long_channel_eq_setting_r  <= 8'h00;
         mode_sel_r                 <= rxeq_pkg::RXEQ_FIXED;
         programmed_eq_use_r        <= 1'b0;
         eq_offset_sign_r           <= 1'b0;
         eq_offset_magnitude_r      <= 4'h0;
         sweep_upper_limit_r        <= rxeq_pkg::SWEEP_UPPER_RST;
         eye_height_limits_r        <= EYE_LIMIT_DEFAULT;
      end
      else if (clk_en && reg_wr)
         case (reg_addr)
            rxeq_pkg::CONN1_EQ_OFS: conn_rx_lane1_eq_setting_r <= reg_wdata[3:0];
            rxeq_pkg::CONN2_EQ_OFS: conn_rx_lane2_eq_setting_r <= reg_wdata[3:0];
            rxeq_pkg::HOST1_EQ_OFS: host_rx_lane1_eq_setting_r <= reg_wdata[3:0];
            rxeq_pkg::HOST2_EQ_OFS: host_rx_lane2_eq_setting_r <= reg_wdata[3:0];
            rxeq_pkg::LONG_EQ_OFS:  long_channel_eq_setting_r  <= reg_wdata[7:0];
            rxeq_pkg::ADAPT_CTL_OFS:
            begin
               mode_sel_r            <= reg_wdata[rxeq_pkg::MODE_LSB +: 2];
               programmed_eq_use_r   <= reg_wdata[rxeq_pkg::USE_BIT];
               eq_offset_sign_r      <= reg_wdata[rxeq_pkg::SIGN_BIT];
               eq_offset_magnitude_r <= reg_wdata[rxeq_pkg::OFFSET_LSB +: 4];
               sweep_upper_limit_r   <= reg_wdata[rxeq_pkg::UPPER_LSB +: 4];
            end
            rxeq_pkg::EYE_LIM_OFS:  eye_height_limits_r <= reg_wdata[7:0];
            default: ;
         endcase
   end

   // ***************************************************************
   // Effective mode of the connector-facing receivers.
   // ***************************************************************
   rxeq_pkg::rxeq_mode_t conn_mode;

   // Strap mode offers only fixed or sweep; fast exists in serial mode alone.
   always_comb
   begin
      if (serial_now)
         case (mode_sel_r)
            rxeq_pkg::RXEQ_FAST:  conn_mode = rxeq_pkg::RXEQ_FAST;
            rxeq_pkg::RXEQ_SWEEP: conn_mode = rxeq_pkg::RXEQ_SWEEP;
            default:              conn_mode = rxeq_pkg::RXEQ_FIXED;
         endcase
      else if (adapt_en_strap)
         conn_mode = rxeq_pkg::RXEQ_SWEEP;
      else
         conn_mode = rxeq_pkg::RXEQ_FIXED;
   end

   // ***************************************************************
   // Per-lane adaptation of the connector-facing receivers.
   // ***************************************************************
   logic [3:0]          lane_set   [2];
   logic [3:0]          lane_fixed [2];
   logic [3:0]          lane_long  [2];
   logic [1:0]          lane_busy;
   rxeq_pkg::rxeq_eye_t lane_eye   [2];

   assign lane_fixed[0] = serial_now ? conn_rx_lane1_eq_setting_r : conn_strap_idx;
   assign lane_fixed[1] = serial_now ? conn_rx_lane2_eq_setting_r : conn_strap_idx;
   assign lane_long[0]  = long_channel_eq_setting_r[3:0];
   assign lane_long[1]  = long_channel_eq_setting_r[7:4];
   assign lane_eye[0]   = eye_lane1;
   assign lane_eye[1]   = eye_lane2;

   generate
      for (genvar gl = 0; gl < 2; gl++)
      begin : g_lane
         rxeq_pkg::rxeq_state_t state_r;
         logic [3:0]            cand_r;
         logic [3:0]            best_idx_r;
         logic [7:0]            best_eye_r;
         logic [3:0]            adopted_r;
         logic [3:0]            short_set;
         logic [3:0]            long_set;
         logic [4:0]            raised;
         logic [3:0]            offset_set;
         logic [3:0]            pick_idx;

         // Without the use bit the programmed pair is ignored for the straps.
         assign short_set = programmed_eq_use_r ? lane_fixed[gl] : conn_strap_idx;
         assign long_set  = programmed_eq_use_r ? lane_long[gl]  : conn_strap_idx;

         // The final candidate may itself be the best, so it is judged here.
         assign pick_idx = (lane_eye[gl].valid && (lane_eye[gl].height > best_eye_r))
                           ? cand_r : best_idx_r;

         // Offset applied to the sweep result, clamped at both ends.
         assign raised = {1'b0, pick_idx} + {1'b0, eq_offset_magnitude_r};
         always_comb
         begin
            if (!eq_offset_sign_r)
               offset_set = raised[4] ? rxeq_pkg::EQ_MAX : raised[3:0];
            else if (pick_idx < eq_offset_magnitude_r)
               offset_set = 4'h0;
            else
               offset_set = pick_idx - eq_offset_magnitude_r;
         end

         // A new insertion starts the adaptation for the selected mode.
         always_ff @(posedge clock or negedge arst_n)
         begin
            if (!arst_n)
            begin
               state_r    <= rxeq_pkg::ST_IDLE;
               cand_r     <= 4'h0;
               best_idx_r <= 4'h0;
               best_eye_r <= 8'h00;
               adopted_r  <= 4'h0;
            end
            else if (clk_en)
               case (state_r)
                  rxeq_pkg::ST_IDLE:
                  begin
                     if (insert_pulse[gl] && conn_mode == rxeq_pkg::RXEQ_SWEEP)
                     begin
                        state_r    <= rxeq_pkg::ST_SWEEP;
                        cand_r     <= 4'h0;
                        best_idx_r <= 4'h0;
                        best_eye_r <= 8'h00;
                     end
                     else if (insert_pulse[gl] && conn_mode == rxeq_pkg::RXEQ_FAST)
                        state_r <= rxeq_pkg::ST_FAST;
                  end
                  rxeq_pkg::ST_SWEEP:
                  begin
                     if (lane_eye[gl].valid)
                     begin
                        best_idx_r <= pick_idx;
                        if (lane_eye[gl].height > best_eye_r)
                           best_eye_r <= lane_eye[gl].height;
                        if (cand_r >= sweep_upper_limit_r)
                        begin
                           adopted_r <= offset_set;
                           state_r   <= rxeq_pkg::ST_IDLE;
                        end
                        else
                           cand_r <= cand_r + 4'h1;
                     end
                  end
                  rxeq_pkg::ST_FAST:
                  begin
                     if (lane_eye[gl].valid)
                     begin
                        // A tall eye means little loss ahead of the receiver.
                        adopted_r <= (lane_eye[gl].height >= eye_height_limits_r)
                                     ? short_set : long_set;
                        state_r   <= rxeq_pkg::ST_IDLE;
                     end
                  end
                  default: state_r <= rxeq_pkg::ST_IDLE;
               endcase
         end

         // Adaptive modes hold the adopted value between insertions.
         always_comb
         begin
            if (state_r == rxeq_pkg::ST_SWEEP)
               lane_set[gl] = cand_r;
            else if (conn_mode == rxeq_pkg::RXEQ_FIXED)
               lane_set[gl] = lane_fixed[gl];
            else
               lane_set[gl] = adopted_r;
         end

         assign lane_busy[gl] = (state_r != rxeq_pkg::ST_IDLE);
      end
   endgenerate

   // ***************************************************************
   // Applied settings, registered onto the outputs.
   // ***************************************************************
   rxeq_pkg::rxeq_settings_t settings_nxt;

   // Host receivers never adapt.
   assign settings_nxt.conn1 = lane_set[0];
   assign settings_nxt.conn2 = lane_set[1];
   assign settings_nxt.host1 = serial_now ? host_rx_lane1_eq_setting_r : host_strap_idx;
   assign settings_nxt.host2 = serial_now ? host_rx_lane2_eq_setting_r : host_strap_idx;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         eq_settings <= '0;
         serial_mode <= 1'b0;
         adapt_busy  <= 2'h0;
      end
      else if (clk_en)
      begin
         eq_settings <= settings_nxt;
         serial_mode <= serial_now;
         adapt_busy  <= lane_busy;
      end
   end

   // ***************************************************************
   // Register read port.
   // ***************************************************************
   logic [31:0] rdata_nxt;

   // Unmapped addresses read as zero.
   always_comb
   begin
      rdata_nxt = 32'h0000_0000;
      case (reg_addr)
         rxeq_pkg::CONN1_EQ_OFS:  rdata_nxt[3:0] = conn_rx_lane1_eq_setting_r;
         rxeq_pkg::CONN2_EQ_OFS:  rdata_nxt[3:0] = conn_rx_lane2_eq_setting_r;
         rxeq_pkg::HOST1_EQ_OFS:  rdata_nxt[3:0] = host_rx_lane1_eq_setting_r;
         rxeq_pkg::HOST2_EQ_OFS:  rdata_nxt[3:0] = host_rx_lane2_eq_setting_r;
         rxeq_pkg::LONG_EQ_OFS:   rdata_nxt[7:0] = long_channel_eq_setting_r;
         rxeq_pkg::ADAPT_CTL_OFS:
         begin
            rdata_nxt[rxeq_pkg::MODE_LSB +: 2]   = mode_sel_r;
            rdata_nxt[rxeq_pkg::USE_BIT]         = programmed_eq_use_r;
            rdata_nxt[rxeq_pkg::SIGN_BIT]        = eq_offset_sign_r;
            rdata_nxt[rxeq_pkg::OFFSET_LSB +: 4] = eq_offset_magnitude_r;
            rdata_nxt[rxeq_pkg::UPPER_LSB +: 4]  = sweep_upper_limit_r;
         end
         rxeq_pkg::EYE_LIM_OFS:   rdata_nxt[7:0] = eye_height_limits_r;
         rxeq_pkg::STATUS_OFS:
         begin
            rdata_nxt[15:0]                      = settings_nxt;
            rdata_nxt[rxeq_pkg::STAT_SER_BIT]    = serial_now;
            rdata_nxt[rxeq_pkg::STAT_BSY_LSB +: 2] = lane_busy;
         end
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end

   // Read data stand for exactly the cycle after the strobe.
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         reg_rdata <= 32'h0000_0000;
      else if (clk_en)
         reg_rdata <= reg_rd ? rdata_nxt : 32'h0000_0000;
   end

endmodule // rxeq_select_ctrl

// *** rtl/rxeq_pkg.sv ***
/*
 * Constants, types and register map of the receive equalization select block.
 * Assumes a 32-bit register port with word-aligned byte addresses.
 */
package rxeq_pkg;

   // ***************************************************************
   // Register map (byte addresses).
   // ***************************************************************
   localparam logic [7:0] CONN1_EQ_OFS  = 8'h00;
   localparam logic [7:0] CONN2_EQ_OFS  = 8'h04;
   localparam logic [7:0] HOST1_EQ_OFS  = 8'h08;
   localparam logic [7:0] HOST2_EQ_OFS  = 8'h0c;
   localparam logic [7:0] LONG_EQ_OFS   = 8'h10;
   localparam logic [7:0] ADAPT_CTL_OFS = 8'h14;
   localparam logic [7:0] EYE_LIM_OFS   = 8'h18;
   localparam logic [7:0] STATUS_OFS    = 8'h1c;

   // ***************************************************************
   // Field positions of the adaptive control and status registers.
   // ***************************************************************
   localparam int MODE_LSB     = 0;
   localparam int USE_BIT      = 2;
   localparam int SIGN_BIT     = 3;
   localparam int OFFSET_LSB   = 4;
   localparam int UPPER_LSB    = 8;
   localparam int STAT_SER_BIT = 16;
   localparam int STAT_BSY_LSB = 17;

   // ***************************************************************
   // Reset values and encodings.
   // ***************************************************************
   localparam logic [3:0] SWEEP_UPPER_RST = 4'h8;
   localparam logic [7:0] EYE_LIMIT_RST   = 8'h40;
   localparam logic [3:0] EQ_MAX          = 4'hf;
   localparam logic [1:0] LVL_F           = 2'h2;
   localparam logic [1:0] LVL_1           = 2'h3;
   localparam logic [1:0] STRAP_TAKE_CNT  = 2'h2;

   // Equalization modes as written by software.
   typedef enum logic [1:0] {
      RXEQ_FIXED = 2'h0,
      RXEQ_FAST  = 2'h1,
      RXEQ_SWEEP = 2'h2
   } rxeq_mode_t;

   // Adaptation state of one connector-facing lane.
   typedef enum {
      ST_IDLE,
      ST_SWEEP,
      ST_FAST
   } rxeq_state_t;

   // Applied settings of all four receivers.
   typedef struct packed {
      logic [3:0] conn1;
      logic [3:0] conn2;
      logic [3:0] host1;
      logic [3:0] host2;
   } rxeq_settings_t;

   // Eye estimate from one connector-facing receiver.
   typedef struct packed {
      logic       valid;
      logic [7:0] height;
   } rxeq_eye_t;

endpackage

// *** dv/rxeq_select_checker.sv ***
/*
 * Port checks of the receive equalization select block.
 * Assumes one clock, an asynchronous active-low reset and clk_en held high.
 */
`timescale 1ns/1ps

module rxeq_select_checker
(
   // Clock and reset.
   input wire logic                     clock,
   input wire logic                     arst_n,
   // Inputs of the block.
   input wire logic [1:0]               insert_pulse,
   input wire rxeq_pkg::rxeq_eye_t      eye_lane1,
   input wire logic [7:0]               reg_addr,
   input wire logic                     reg_wr,
   input wire logic                     reg_rd,
   // Outputs of the block.
   input wire logic [31:0]              reg_rdata,
   input wire rxeq_pkg::rxeq_settings_t eq_settings,
   input wire logic                     serial_mode,
   input wire logic [1:0]               adapt_busy
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);

   // Settle count; strap capture legally moves the outputs just after reset.
   logic [3:0] up_r;
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         up_r <= 4'h0;
      else if (up_r != 4'hf)
         up_r <= up_r + 4'h1;
   end

   rdata_idle_a:
      assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside the read answer cycle");
   status_read_a:
      assert property ($past(reg_rd) && $past(reg_addr) == rxeq_pkg::STATUS_OFS
         |-> reg_rdata[15:0] == eq_settings && reg_rdata[16] == serial_mode)
      else $error("status read differs from applied settings");
   host_shared_a:
      assert property (up_r == 4'hf && !serial_mode |-> eq_settings.host1 == eq_settings.host2)
      else $error("host lanes differ in strap mode");
   host_hold_a:
      assert property (up_r == 4'hf && !$past(reg_wr) && !$past(reg_wr, 2)
         |-> $stable({eq_settings.host1, eq_settings.host2}))
      else $error("host setting moved without a write");
   serial_hold_a:
      assert property (up_r == 4'hf |-> $stable(serial_mode))
      else $error("mode changed after strap capture");
   busy_start_a:
      assert property ($rose(adapt_busy[0]) |-> $past(insert_pulse[0])
         || $past(insert_pulse[0], 2) || $past(insert_pulse[0], 3))
      else $error("adaptation began without insertion");
   busy_end_a:
      assert property ($fell(adapt_busy[0]) |-> $past(eye_lane1.valid)
         || $past(eye_lane1.valid, 2) || $past(eye_lane1.valid, 3))
      else $error("adaptation ended without an eye estimate");
   sweep_bound_a:
      assert property ($rose(adapt_busy[0]) |-> ##[1:200] !adapt_busy[0])
      else $error("adaptation did not finish");

   // Main scenarios.
   lane1_done_c: cover property ($fell(adapt_busy[0]));
   lane2_done_c: cover property ($fell(adapt_busy[1]));
   status_rd_c: cover property ($past(reg_rd) && $past(reg_addr) == rxeq_pkg::STATUS_OFS);
endmodule // rxeq_select_checker

// *** dv/rxeq_eye_model.sv ***
/*
 * Eye height estimator model for the two connector receivers.
 * Assumes the applied settings show on the block's output one cycle late.
 */
`timescale 1ns/1ps

module rxeq_eye_model
#(
   parameter logic [3:0] PEAK = 4'h6
)
(
   // Clock and reset.
   input wire logic           clock,
   input wire logic           arst_n,
   // Lane state and channel shape.
   input wire logic [1:0]     busy,
   input wire logic [3:0]     set1,
   input wire logic [3:0]     set2,
   input wire logic [7:0]     base,
   input wire logic [3:0]     dly,
   // Estimates.
   output rxeq_pkg::rxeq_eye_t eye1,
   output rxeq_pkg::rxeq_eye_t eye2
);
   logic [3:0]          cnt [2];
   rxeq_pkg::rxeq_eye_t e   [2];
   logic [3:0]          s   [2];
   assign s[0] = set1;
   assign s[1] = set2;
   assign eye1 = e[0];
   assign eye2 = e[1];

   // Height falls by four per step away from the peak, so the best is unique.
   function automatic logic [7:0] hgt(input logic [3:0] v);
      logic [3:0] d;
      d = (v > PEAK) ? v - PEAK : PEAK - v;
      return base - {2'b00, d, 2'b00};
   endfunction

   // One estimate every dly cycles while busy; height toggles when not valid.
   always_ff @(posedge clock or negedge arst_n)
   begin
      for (int i = 0; i < 2; i++)
         if (!arst_n)
         begin
            cnt[i] <= 4'h0;
            e[i]   <= '{1'b0, 8'h5a};
         end
         else if (busy[i] && cnt[i] == dly - 4'h1)
         begin
            cnt[i] <= 4'h0;
            e[i]   <= '{1'b1, hgt(s[i])};
         end
         else
         begin
            cnt[i] <= busy[i] ? cnt[i] + 4'h1 : 4'h0;
            e[i]   <= '{1'b0, ~e[i].height};
         end
   end
endmodule // rxeq_eye_model

// *** dv/rxeq_select_ctrl_bench.sv ***
/*
 * Self-checking bench of the receive equalization select block.
 * Assumes the eye model in the same folder and clk_en held high.
 */
`timescale 1ns/1ps

module rxeq_select_ctrl_bench;
   logic clock = 1'b0, arst_n = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [1:0] mode_strap = 2'h3, conn_eq_strap_high = 2'h2, conn_eq_strap_low = 2'h1;
   logic [1:0] host_eq_strap_high = 2'h1, host_eq_strap_low = 2'h3, insert_pulse = 2'h0;
   logic adaptive_disable_strap_n = 1'b0, serial_mode;
   logic [7:0] reg_addr = 8'h00, base = 8'ha0;
   logic [3:0] dly = 4'h3;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [1:0] adapt_busy;
   rxeq_pkg::rxeq_eye_t eye_lane1, eye_lane2;
   rxeq_pkg::rxeq_settings_t eq_settings;
   int failures = 0, checked = 0;

   rxeq_select_ctrl dut (.clock, .arst_n, .clk_en, .mode_strap, .conn_eq_strap_high,
      .conn_eq_strap_low, .host_eq_strap_high, .host_eq_strap_low,
      .adaptive_disable_strap_n, .insert_pulse, .eye_lane1, .eye_lane2, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .eq_settings, .serial_mode, .adapt_busy);
   rxeq_eye_model em (.clock, .arst_n, .busy(adapt_busy), .set1(eq_settings.conn1),
      .set2(eq_settings.conn2), .base, .dly, .eye1(eye_lane1), .eye2(eye_lane2));

   always #10 clock = ~clock;

   // ************************************************************
   // Shared tasks.
   // ************************************************************
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Reset is held two cycles while the straps settle, then capture runs.
   task automatic boot(input logic [1:0] m, input logic ad);
      @(posedge clock);
      arst_n <= 1'b0;
      mode_strap <= m;
      adaptive_disable_strap_n <= ad;
      conn_eq_strap_high <= 2'h2;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      repeat (10) @(posedge clock);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      cmp("rdata", e, reg_rdata);
   endtask

   // Start one adaptation and wait, bounded, until the lane is idle again.
   task automatic adapt(input int l, input logic [31:0] c, input logic [7:0] b,
                        input logic [3:0] e);
      int n;
      wr(rxeq_pkg::ADAPT_CTL_OFS, c);
      @(posedge clock);
      base <= b;
      insert_pulse[l] <= 1'b1;
      @(posedge clock);
      insert_pulse <= 2'h0;
      repeat (4) @(posedge clock);
      n = 0;
      while (adapt_busy[l] !== 1'b0 && n < 300)
      begin
         @(posedge clock);
         n++;
      end
      if (n == 300) failures++;
      repeat (2) @(posedge clock);
      #1;
      cmp("setting", {28'h0, e}, {28'h0, l ? eq_settings.conn2 : eq_settings.conn1});
   endtask

   // ************************************************************
   // Scenarios.
   // ************************************************************
   task automatic t_strap();
      boot(2'h3, 1'b0);
      cmp("eq", 32'h9977, 32'(eq_settings));
      cmp("mode", 32'h0, {31'h0, serial_mode});
      @(posedge clock);
      conn_eq_strap_high <= 2'h0;
      repeat (6) @(posedge clock);
      cmp("eq", 32'h9977, 32'(eq_settings));
      adapt(0, 32'h5, 8'h30, 4'h9);
      $display("strap fixed done");
   endtask

   task automatic t_strap_sweep();
      boot(2'h3, 1'b1);
      adapt(0, 32'h800, 8'ha0, 4'h6);
      $display("strap sweep done");
   endtask

   task automatic t_regs();
      boot(2'h2, 1'b0);
      cmp("mode", 32'h1, {31'h0, serial_mode});
      rd(rxeq_pkg::ADAPT_CTL_OFS, 32'h800);
      rd(rxeq_pkg::EYE_LIM_OFS, 32'h40);
      rd(8'h20, 32'h0);
      wr(rxeq_pkg::CONN1_EQ_OFS, 32'h3);
      wr(rxeq_pkg::CONN2_EQ_OFS, 32'h5);
      wr(rxeq_pkg::HOST1_EQ_OFS, 32'ha);
      wr(rxeq_pkg::HOST2_EQ_OFS, 32'hf);
      repeat (2) @(posedge clock);
      cmp("eq", 32'h35af, 32'(eq_settings));
      rd(rxeq_pkg::STATUS_OFS, 32'h135af);
      $display("registers done");
   endtask

   task automatic t_sweep();
      adapt(0, 32'h822, 8'ha0, 4'h8);
      adapt(0, 32'h8c2, 8'ha0, 4'hf);
      dly <= 4'h6;
      adapt(0, 32'h83a, 8'ha0, 4'h3);
      dly <= 4'h3;
      adapt(0, 32'h89a, 8'ha0, 4'h0);
      adapt(1, 32'h302, 8'ha0, 4'h3);
      $display("sweep done");
   endtask

   task automatic t_fast();
      wr(rxeq_pkg::LONG_EQ_OFS, 32'hdc);
      adapt(0, 32'h5, 8'h80, 4'h3);
      adapt(0, 32'h5, 8'h30, 4'hc);
      adapt(1, 32'h5, 8'h30, 4'hd);
      adapt(0, 32'h1, 8'h30, 4'h9);
      wr(rxeq_pkg::EYE_LIM_OFS, 32'h90);
      adapt(0, 32'h5, 8'h80, 4'hc);
      $display("fast done");
   endtask

   initial
   begin
      t_strap();
      t_strap_sweep();
      t_regs();
      t_sweep();
      t_fast();
      results();
   end

   // Watchdog well beyond the few hundred cycles the scenarios need.
   initial
   begin
      repeat (20000) @(posedge clock);
      failures++;
      results();
   end
endmodule // rxeq_select_ctrl_bench

bind rxeq_select_ctrl rxeq_select_checker chk (.clock, .arst_n, .insert_pulse, .eye_lane1,
   .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .eq_settings, .serial_mode, .adapt_busy);
